// ### hdl/psp_top.sv
// Serial programming, counter selection and phase detector of the synthesizer
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01 - Ping-pong select: high primary, low secondary
// R02 - Enhance strobe high: shift eight bits, MSB first
// R03 - Extra bits buffered on enhance strobe fall
// R04 - Buffered extra bits act only while enable low
// R05 - Direct select high forces direct pin mode
// R06 - Direct mode takes counter bits from pins
// R07 - Direct mode zeroes M8, M7, R5, R4
// R08 - Write strobe rise copies primary to secondary
// R09 - Extra control bits are active high
// R10 - Detector acts on divider rising edges only
// R11 - Main leads: pump down; ref leads: pump up
// R12 - Pump pulse width follows phase offset
// R13 - Lock node NAND, indicator AND of pumps once quiet for lock_cfg cycles
// R14 - Serial mode: direct low, serial select high
// R15 - Both strobes low: shift twenty bits, MSB first
// R16 - Hop strobe rise copies primary to secondary
// R17 - Aligned edges leave both pumps high
module psp_top (
  input wire logic pclk, // Clock, 250 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [psp_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte enables
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic serial_clock, // Host serial clock
  input wire logic serial_data_in, // Host serial data
  input wire logic enh_write_strobe, // Extra control load strobe
  input wire logic serial_write_strobe, // Counter word write strobe
  input wire logic hop_transfer_strobe, // Primary to secondary copy
  input wire logic direct_mode_select, // Direct pin mode select
  input wire logic serial_mode_select, // Serial mode select
  input wire logic pingpong_select_serial, // Primary or secondary select
  input wire logic extra_ctrl_enable_n, // Extra control enable, low
  input wire psp_pkg::psp_counter_t direct_counter_pins, // Direct mode pins
  input wire logic main_divider_out, // Divided main signal
  input wire logic ref_divider_out, // Divided reference signal
  output psp_pkg::psp_counter_t counter_word, // Word to the counters
  output logic [psp_pkg::EXT_W-1:0] extra_ctrl_out, // Active extra bits
  output logic pump_up_n, // Pump up pulse, low
  output logic pump_down_n, // Pump down pulse, low
  output logic lock_filter_node, // NAND of pump outputs
  output logic lock_indicator // Filtered lock, high
);

  localparam int unsigned CW = psp_pkg::CNT_W;
  localparam int unsigned EW = psp_pkg::EXT_W;
  localparam int unsigned LW = psp_pkg::LOCK_CFG_W;

  // ----------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------
  psp_pkg::psp_pins_t pin_raw, pin, pin_prev;
  logic [CW-1:0] direct_sync;

  assign pin_raw = '{sclk: serial_clock, sdi: serial_data_in, enh_wr: enh_write_strobe,
                     ser_wr: serial_write_strobe, hop_wr: hop_transfer_strobe,
                     dir_sel: direct_mode_select, ser_sel: serial_mode_select,
                     pp_sel: pingpong_select_serial, enh_en_n: extra_ctrl_enable_n,
                     main_div: main_divider_out, ref_div: ref_divider_out};

  psp_sync #(.W($bits(psp_pkg::psp_pins_t))) u_sync_pins (
    .pclk(pclk),
    .presetn(presetn),
    .din(pin_raw),
    .dout(pin)
  );

  psp_sync #(.W(CW)) u_sync_direct (
    .pclk(pclk),
    .presetn(presetn),
    .din(direct_counter_pins),
    .dout(direct_sync)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= '0;
    end else begin
      pin_prev <= pin;
    end
  end

  logic sclk_rise, enh_fall, ser_wr_rise, hop_rise, main_rise, ref_rise;
  assign sclk_rise = pin.sclk && !pin_prev.sclk;
  assign enh_fall = !pin.enh_wr && pin_prev.enh_wr;
  assign ser_wr_rise = pin.ser_wr && !pin_prev.ser_wr;
  assign hop_rise = pin.hop_wr && !pin_prev.hop_wr;
  assign main_rise = pin.main_div && !pin_prev.main_div; // [R10]
  assign ref_rise = pin.ref_div && !pin_prev.ref_div; // [R10]

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  psp_pkg::psp_mode_t mode;
  always_comb begin
    if (pin.dir_sel) begin
      mode = psp_pkg::PSP_MODE_DIRECT; // [R05]
    end else if (pin.ser_sel) begin
      mode = psp_pkg::PSP_MODE_SERIAL; // [R14]
    end else begin
      mode = psp_pkg::PSP_MODE_PARALLEL;
    end
  end

  // ----------------------------------------------------------------
  // Serial shift and transfer registers
  // ----------------------------------------------------------------
  psp_pkg::psp_counter_t primary, secondary;
  logic [EW-1:0] extra_shift, extra_buf;
  logic serial_shift;
  assign serial_shift = (mode == psp_pkg::PSP_MODE_SERIAL) && sclk_rise && !pin.ser_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary <= psp_pkg::CNT_RST;
    end else if (serial_shift && !pin.enh_wr) begin
      primary <= {primary[CW-2:0], pin.sdi}; // [R15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary <= psp_pkg::CNT_RST;
    end else if ((mode == psp_pkg::PSP_MODE_SERIAL) &&
                 ((ser_wr_rise && !pin.enh_wr) || hop_rise)) begin
      secondary <= primary; // [R08] [R16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extra_shift <= psp_pkg::EXT_RST;
    end else if (serial_shift && pin.enh_wr) begin
      extra_shift <= {extra_shift[EW-2:0], pin.sdi}; // [R02]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extra_buf <= psp_pkg::EXT_RST;
    end else if (enh_fall && (mode == psp_pkg::PSP_MODE_SERIAL)) begin
      extra_buf <= extra_shift; // [R03]
    end
  end

  // ----------------------------------------------------------------
  // Outputs to counters and control bits
  // ----------------------------------------------------------------
  psp_pkg::psp_counter_t next_counter;
  always_comb begin
    if (mode == psp_pkg::PSP_MODE_DIRECT) begin
      next_counter = direct_sync; // [R06]
      next_counter.m[psp_pkg::DIR_M_ZERO_LSB +: 2] = 2'h0; // [R07]
      next_counter.r[psp_pkg::DIR_R_ZERO_LSB +: 2] = 2'h0; // [R07]
    end else if (pin.pp_sel) begin
      next_counter = primary; // [R01]
    end else begin
      next_counter = secondary; // [R01]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_word <= psp_pkg::CNT_RST;
      extra_ctrl_out <= psp_pkg::EXT_RST;
    end else begin
      counter_word <= next_counter;
      extra_ctrl_out <= pin.enh_en_n ? psp_pkg::EXT_RST : extra_buf; // [R04] [R09]
    end
  end

  // ----------------------------------------------------------------
  // Phase frequency detector and lock filter
  // ----------------------------------------------------------------
  logic pfd_up, pfd_dn, next_up, next_dn;
  logic [LW-1:0] lock_cfg, lock_cnt;

  always_comb begin
    next_up = pfd_up || ref_rise; // [R11] [R12]
    next_dn = pfd_dn || main_rise; // [R11] [R12]
    if (next_up && next_dn) begin
      next_up = 1'b0; // [R17]
      next_dn = 1'b0; // [R17]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfd_up <= 1'b0;
      pfd_dn <= 1'b0;
      pump_up_n <= 1'b1;
      pump_down_n <= 1'b1;
      lock_filter_node <= 1'b0;
    end else begin
      pfd_up <= next_up;
      pfd_dn <= next_dn;
      pump_up_n <= !next_up;
      pump_down_n <= !next_dn;
      lock_filter_node <= next_up || next_dn; // [R13]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt <= '0;
      lock_indicator <= 1'b0;
    end else begin
      if (next_up || next_dn) begin
        lock_cnt <= '0;
      end else if (lock_cnt != '1) begin
        lock_cnt <= lock_cnt + 1'b1;
      end
      lock_indicator <= !(next_up || next_dn) && (lock_cnt >= lock_cfg); // [R13]
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic wr_en;
  logic [31:0] rd_word;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !psp_pkg::psp_mapped(paddr);
  assign wr_en = psel && penable && pwrite && (paddr == psp_pkg::ADDR_LOCK_CFG);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cfg <= psp_pkg::LOCK_CFG_RST;
    end else if (wr_en) begin
      if (pstrb[0]) begin
        lock_cfg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        lock_cfg[15:8] <= pwdata[15:8];
      end
    end
  end

  always_comb begin
    rd_word = '0;
    unique case (paddr)
      psp_pkg::ADDR_PRIMARY: rd_word[CW-1:0] = primary;
      psp_pkg::ADDR_SECONDARY: rd_word[CW-1:0] = secondary;
      psp_pkg::ADDR_EXTRA: begin
        rd_word[EW-1:0] = extra_buf;
        rd_word[psp_pkg::EXT_EFF_LSB +: EW] = extra_ctrl_out;
      end
      psp_pkg::ADDR_STATUS: begin
        rd_word[psp_pkg::STAT_LOCK] = lock_indicator;
        rd_word[psp_pkg::STAT_PUMP_UP_N] = pump_up_n;
        rd_word[psp_pkg::STAT_PUMP_DN_N] = pump_down_n;
        rd_word[psp_pkg::STAT_DIRECT] = (mode == psp_pkg::PSP_MODE_DIRECT);
        rd_word[psp_pkg::STAT_SERIAL] = (mode == psp_pkg::PSP_MODE_SERIAL);
      end
      psp_pkg::ADDR_LOCK_CFG: rd_word[LW-1:0] = lock_cfg;
      default: rd_word = '0;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_pingpong;
    @(posedge pclk) disable iff (!presetn)
    (!pin.dir_sel && pin.pp_sel) |=> (counter_word == $past(primary));
  endproperty
  a_pingpong: assert property (p_pingpong) else $error("primary not selected"); // [R01]
  property p_extra_shift;
    @(posedge pclk) disable iff (!presetn)
    (serial_shift && pin.enh_wr) |=> (extra_shift == {$past(extra_shift[EW-2:0]), $past(pin.sdi)});
  endproperty
  a_extra_shift: assert property (p_extra_shift) else $error("extra shift wrong"); // [R02]
  property p_extra_hold;
    @(posedge pclk) disable iff (!presetn)
    !enh_fall |=> $stable(extra_buf);
  endproperty
  a_extra_hold: assert property (p_extra_hold) else $error("extra buffer moved"); // [R03]
  property p_extra_gate;
    @(posedge pclk) disable iff (!presetn)
    pin.enh_en_n |=> (extra_ctrl_out == psp_pkg::EXT_RST);
  endproperty
  a_extra_gate: assert property (p_extra_gate) else $error("extra bits not gated"); // [R04]
  property p_direct_zero;
    @(posedge pclk) disable iff (!presetn)
    pin.dir_sel |=> (counter_word.m[8:7] == 2'h0) && (counter_word.r[5:4] == 2'h0);
  endproperty
  a_direct_zero: assert property (p_direct_zero) else $error("direct bits not forced"); // [R07]

  property p_sec_copy;
    @(posedge pclk) disable iff (!presetn)
    ((mode == psp_pkg::PSP_MODE_SERIAL) && ser_wr_rise && !pin.enh_wr)
      |=> (secondary == $past(primary));
  endproperty
  a_sec_copy: assert property (p_sec_copy) else $error("secondary not loaded"); // [R08]

  property p_pump_dir;
    @(posedge pclk) disable iff (!presetn)
    (main_rise && !ref_rise && !pfd_up && !pfd_dn) |=> (!pump_down_n && pump_up_n);
  endproperty
  a_pump_dir: assert property (p_pump_dir) else $error("pump down missing"); // [R11]

  property p_pump_hold;
    @(posedge pclk) disable iff (!presetn)
    (!pump_up_n && !main_rise) |=> !pump_up_n;
  endproperty
  a_pump_hold: assert property (p_pump_hold) else $error("pump up ended early"); // [R12]

  property p_lock_and;
    @(posedge pclk) disable iff (!presetn)
    lock_indicator |-> (pump_up_n && pump_down_n && !lock_filter_node);
  endproperty
  a_lock_and: assert property (p_lock_and) else $error("lock while pumping"); // [R13]

  property p_aligned;
    @(posedge pclk) disable iff (!presetn)
    (main_rise && ref_rise && !pfd_up && !pfd_dn) |=> (pump_up_n && pump_down_n);
  endproperty
  a_aligned: assert property (p_aligned) else $error("pulse on aligned edges"); // [R17]

endmodule // psp_top
`default_nettype wire

// ### include/psp_pkg.sv
// Shared constants and carrier types of the synthesizer control block
`default_nettype none
package psp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 20;
  localparam int unsigned EXT_W = 8;
  localparam int unsigned LOCK_CFG_W = 16;
  localparam int unsigned ADDR_W = 8;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_PRIMARY = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SECONDARY = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_EXTRA = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_LOCK_CFG = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned EXT_EFF_LSB = 8;
  localparam int unsigned STAT_LOCK = 0;
  localparam int unsigned STAT_PUMP_UP_N = 1;
  localparam int unsigned STAT_PUMP_DN_N = 2;
  localparam int unsigned STAT_DIRECT = 3;
  localparam int unsigned STAT_SERIAL = 4;
  localparam int unsigned DIR_M_ZERO_LSB = 7;
  localparam int unsigned DIR_R_ZERO_LSB = 4;
  localparam logic [LOCK_CFG_W-1:0] LOCK_CFG_RST = 16'h0010;
  localparam logic [CNT_W-1:0] CNT_RST = 20'h00000;
  localparam logic [EXT_W-1:0] EXT_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSP_MODE_PARALLEL,
    PSP_MODE_SERIAL,
    PSP_MODE_DIRECT
  } psp_mode_t;

  typedef struct packed {
    logic [8:0] m;
    logic [5:0] r;
    logic pre_en_n;
    logic [3:0] a;
  } psp_counter_t;

  typedef struct packed {
    logic sclk;
    logic sdi;
    logic enh_wr;
    logic ser_wr;
    logic hop_wr;
    logic dir_sel;
    logic ser_sel;
    logic pp_sel;
    logic enh_en_n;
    logic main_div;
    logic ref_div;
  } psp_pins_t;

  // Address decode used by the error path only
  function automatic logic psp_mapped(input logic [ADDR_W-1:0] addr);
    psp_mapped = (addr == ADDR_PRIMARY) || (addr == ADDR_SECONDARY) ||
                 (addr == ADDR_EXTRA) || (addr == ADDR_STATUS) ||
                 (addr == ADDR_LOCK_CFG);
  endfunction

endpackage
`default_nettype wire

// ### hdl/psp_sync.sv
// Two-flop synchroniser for pins from outside the pclk domain
`timescale 1ns/1ps
`default_nettype none
module psp_sync #(
  parameter int unsigned W = 1
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic [W-1:0] din, // Asynchronous pins
  output logic [W-1:0] dout // Synchronised pins
);

  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // psp_sync
`default_nettype wire

// ### verif/psp_host_model.sv
// Host side model driving the serial programming pins
`timescale 1ns/1ps
`default_nettype none
module psp_host_model (
  input wire logic pclk, // Clock
  output logic sclk, // Serial clock, still outside frames
  output logic sdi, // Serial data
  output logic enh_wr, // Extra control strobe
  output logic ser_wr, // Counter word strobe
  output logic hop_wr // Hop copy strobe
);
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    enh_wr = 1'b0;
    ser_wr = 1'b0;
    hop_wr = 1'b0;
  end
  // Shift n bits MSB first, 32 ns serial period
  task automatic shift(input logic [19:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sdi <= bits[i];
      repeat (4) @(posedge pclk);
      sclk <= 1'b1;
      repeat (4) @(posedge pclk);
      sclk <= 1'b0;
    end
    @(posedge pclk) sdi <= ~bits[0];
  endtask
  task automatic set_enh(input logic v);
    @(posedge pclk) enh_wr <= v;
    repeat (8) @(posedge pclk);
  endtask
  // Pulse a copy strobe: 0 counter word, 1 hop
  task automatic strobe(input logic hop);
    @(posedge pclk);
    if (hop) hop_wr <= 1'b1;
    else ser_wr <= 1'b1;
    repeat (8) @(posedge pclk);
    hop_wr <= 1'b0;
    ser_wr <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule // psp_host_model
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench of the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic sclk, sdi, enh_wr, ser_wr, hop_wr, dir_sel, ser_sel, pp_sel, enh_en_n;
  logic main_div, ref_div, pump_up_n, pump_down_n, lock_filter_node, lock_indicator, err;
  logic [7:0] extra_ctrl_out;
  psp_pkg::psp_counter_t pins, counter_word;
  int n_fail, total_checks;

  psp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clock(sclk), .serial_data_in(sdi),
    .enh_write_strobe(enh_wr), .serial_write_strobe(ser_wr), .hop_transfer_strobe(hop_wr),
    .direct_mode_select(dir_sel), .serial_mode_select(ser_sel),
    .pingpong_select_serial(pp_sel), .extra_ctrl_enable_n(enh_en_n),
    .direct_counter_pins(pins), .main_divider_out(main_div), .ref_divider_out(ref_div),
    .counter_word(counter_word), .extra_ctrl_out(extra_ctrl_out), .pump_up_n(pump_up_n),
    .pump_down_n(pump_down_n), .lock_filter_node(lock_filter_node),
    .lock_indicator(lock_indicator));
  psp_host_model host (.pclk(pclk), .sclk(sclk), .sdi(sdi), .enh_wr(enh_wr),
    .ser_wr(ser_wr), .hop_wr(hop_wr));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One APB transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) check("pready", 0, 1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs();
    apb(1'b0, psp_pkg::ADDR_LOCK_CFG, 0);
    check("lock_cfg_rst", q, 32'h00000010);
    apb(1'b1, psp_pkg::ADDR_LOCK_CFG, 32'h00000020);
    apb(1'b0, psp_pkg::ADDR_LOCK_CFG, 0);
    check("lock_cfg_rw", q, 32'h00000020);
    apb(1'b1, psp_pkg::ADDR_PRIMARY, 32'h000FFFFF);
    apb(1'b0, psp_pkg::ADDR_PRIMARY, 0);
    check("primary_ro", q, 32'h00000000);
    apb(1'b0, 8'h14, 0);
    check("unmapped_err", {31'h0, err}, 32'h00000001);
    check("unmapped_data", q, 32'h00000000);
    apb(1'b0, psp_pkg::ADDR_STATUS, 0);
    check("status_mode", q[4:1], 4'hB);
    check("mapped_err", {31'h0, err}, 32'h00000000);
  endtask

  task automatic t_serial();
    host.shift(20'hA5C3B, 20);
    repeat (10) @(posedge pclk);
    apb(1'b0, psp_pkg::ADDR_PRIMARY, 0);
    check("primary", q, 32'h000A5C3B);
    check("cw_primary", counter_word, 20'hA5C3B);
    pp_sel <= 1'b0;
    repeat (8) @(posedge pclk);
    check("cw_secondary_rst", counter_word, 20'h00000);
    host.strobe(1'b0);
    check("cw_after_wr", counter_word, 20'hA5C3B);
    host.shift(20'h5A3C4, 20);
    repeat (10) @(posedge pclk);
    check("cw_before_hop", counter_word, 20'hA5C3B);
    host.strobe(1'b1);
    check("cw_after_hop", counter_word, 20'h5A3C4);
    ser_sel <= 1'b0;
    host.shift(20'h0F0F0, 20);
    repeat (10) @(posedge pclk);
    apb(1'b0, psp_pkg::ADDR_PRIMARY, 0);
    check("no_shift_parallel", q, 32'h0005A3C4);
    ser_sel <= 1'b1;
    pp_sel <= 1'b1;
  endtask

  task automatic t_extra();
    enh_en_n <= 1'b0;
    host.set_enh(1'b1);
    host.shift(20'h000C6, 8);
    repeat (10) @(posedge pclk);
    apb(1'b0, psp_pkg::ADDR_EXTRA, 0);
    check("extra_before_fall", q[7:0], 8'h00);
    check("out_before_fall", extra_ctrl_out, 8'h00);
    host.set_enh(1'b0);
    apb(1'b0, psp_pkg::ADDR_EXTRA, 0);
    check("extra_buf", q[7:0], 8'hC6);
    check("extra_eff", q[15:8], 8'hC6);
    check("out_enabled", extra_ctrl_out, 8'hC6);
    enh_en_n <= 1'b1;
    repeat (8) @(posedge pclk);
    check("out_disabled", extra_ctrl_out, 8'h00);
    apb(1'b0, psp_pkg::ADDR_PRIMARY, 0);
    check("primary_kept", q, 32'h0005A3C4);
  endtask

  task automatic t_direct();
    for (int s = 0; s < 2; s++) begin
      ser_sel <= s[0];
      dir_sel <= 1'b1;
      pins <= s[0] ? 20'hFFFFF : 20'h12345;
      repeat (8) @(posedge pclk);
      check("direct_cw", counter_word, s[0] ? 20'h3F9FF : 20'h12145);
      apb(1'b0, psp_pkg::ADDR_STATUS, 0);
      check("status_direct", q[3], 1'b1);
    end
    dir_sel <= 1'b0;
    repeat (8) @(posedge pclk);
    check("cw_back", counter_word, 20'h5A3C4);
  endtask

  // Dividers rise at dm and dr, fall 12 cycles later; count pump activity
  task automatic pd_run(input int dm, input int dr, input int xd, input int xu);
    int nd, nu, nn, nl;
    nd = 0;
    nu = 0;
    nn = 0;
    nl = 0;
    for (int t = 0; t < 34; t++) begin
      @(posedge pclk);
      main_div <= (t >= dm && t < dm + 12);
      ref_div <= (t >= dr && t < dr + 12);
      #1;
      nd += (pump_down_n === 1'b0);
      nu += (pump_up_n === 1'b0);
      nn += (lock_filter_node === 1'b1);
      nl += (lock_indicator === 1'b1 && lock_filter_node === 1'b1);
    end
    check("pump_down_width", nd, xd);
    check("pump_up_width", nu, xu);
    check("node_width", nn, xd + xu);
    check("lock_while_pump", nl, 0);
  endtask

  task automatic t_phase();
    pd_run(0, 5, 5, 0);
    pd_run(7, 0, 0, 7);
    repeat (5) @(posedge pclk);
    #1;
    check("lock_early", lock_indicator, 1'b0);
    repeat (5) @(posedge pclk);
    #1;
    check("lock_set", lock_indicator, 1'b1);
    pd_run(3, 3, 0, 0);
    repeat (40) @(posedge pclk);
    check("lock_quiet", lock_indicator, 1'b1);
  endtask

  initial begin
    n_fail = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    dir_sel = 1'b0;
    ser_sel = 1'b1;
    pp_sel = 1'b1;
    enh_en_n = 1'b1;
    pins = 20'h00000;
    main_div = 1'b0;
    ref_div = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    check("cw_rst", counter_word, 20'h00000);
    t_regs();
    t_serial();
    t_extra();
    t_direct();
    t_phase();
    conclude();
  end

  initial begin
    #100000;
    n_fail++;
    conclude();
  end
endmodule // tb
`default_nettype wire
